// *** src/svcl_defines.vh ***
`ifndef SVCL_DEFINES_VH
`define SVCL_DEFINES_VH

// Object dictionary indices, 16-bit
`define SVCL_IDX_QSTOP_DECEL     16'h6085
`define SVCL_IDX_PROFILE_SELECT  16'h6086
`define SVCL_IDX_JERK            16'h60a4
`define SVCL_IDX_ACCEL_LIMIT     16'h60c5
`define SVCL_IDX_DECEL_LIMIT     16'h60c6
`define SVCL_IDX_VEL_GAINS       16'h2381
`define SVCL_IDX_CUR_GAINS       16'h2380
`define SVCL_IDX_VEL_CMD_FILTER  16'h2108
`define SVCL_IDX_VEL_OUT_FILTER  16'h2106
`define SVCL_IDX_PEAK_LIMIT      16'h2110
`define SVCL_IDX_CONT_LIMIT      16'h2111
`define SVCL_IDX_PEAK_TIME       16'h2112
`define SVCL_IDX_VEL_CMD_RO      16'h2250
`define SVCL_IDX_CMD_CURRENT     16'h221d
`define SVCL_IDX_LIM_CURRENT     16'h221e

// Profile type codes
`define SVCL_PROF_TRAP           16'h0000
`define SVCL_PROF_SCURVE         16'h0003
`define SVCL_PROF_VELOCITY       16'hffff

// Filter modes
`define SVCL_FILT_BYPASS         2'h0
`define SVCL_FILT_SINGLE_POLE    2'h1
`define SVCL_FILT_BUTTERWORTH    2'h2
`define SVCL_FILT_BIQUAD         2'h3

// Jerk array element count and control word start bit
`define SVCL_JERK_COUNT          8'h01
`define SVCL_CW_START_BIT        4

// Control sample period
`define SVCL_CLK_NS              10
`define SVCL_SAMPLE_NS           10000
`define SVCL_SAMPLE_CYCLES       (`SVCL_SAMPLE_NS / `SVCL_CLK_NS)

`endif

// *** src/svcl_servo_loops.v ***
// Functional notes
// RQ1 - Zero quick-stop deceleration zeroes velocity at once
// RQ2 - Profile codes: 0 trapezoid, 3 S-curve, -1 velocity
// RQ3 - Unsupported profile code writes are rejected
// RQ4 - Profile selection drives trajectory in position mode
// RQ5 - Profile selection buffered until move start
// RQ6 - Jerk array reports element count at sub-index 0
// RQ7 - Acceleration limit applies while speed grows
// RQ8 - Deceleration limit applies while speed falls
// RQ9 - Velocity error times proportional gain
// RQ10 - Velocity error integral times integral gain
// RQ11 - Filters on velocity command and loop output
// RQ12 - Filters: single pole, Butterworth, or biquad
// RQ13 - Velocity output is current limiter command
// RQ14 - Clamp to user peak, peak within rating
// RQ15 - After peak time, clamp to continuous limit
// RQ16 - Current error times proportional gain
// RQ17 - Current error integral times integral gain
// RQ18 - Current loop output sets PWM duty
// RQ19 - Quick stop ramps velocity down by deceleration
// RQ20 - Control word bit 4 rise latches settings
// RQ21 - Loops run once per fixed sample period
`timescale 1ns/1ps
`include "svcl_defines.vh"

module svcl_servo_loops #(
    parameter DW            = 32,
    parameter SAMPLE_CYCLES = `SVCL_SAMPLE_CYCLES,
    parameter PEAK_RATING   = 32'h00007fff,
    parameter PWM_BITS      = 12
) (
    input  wire                i_clk,
    input  wire                i_reset,
    input  wire                i_wr,
    input  wire                i_rd,
    input  wire [15:0]         i_index,
    input  wire [7:0]          i_subindex,
    input  wire [31:0]         i_wdata,
    output reg  [31:0]         o_rdata,
    output reg                 o_ack,
    output reg                 o_reject,
    input  wire [15:0]         i_control_word,
    input  wire                i_profile_position_mode,
    input  wire                i_quick_stop,
    input  wire signed [31:0]  i_target_velocity,
    input  wire signed [31:0]  i_actual_velocity,
    input  wire signed [31:0]  i_feedback_current,
    output reg  [15:0]         o_active_profile,
    output reg                 o_sample_tick,
    output reg  [PWM_BITS-1:0] o_pwm_duty,
    output reg                 o_pwm_out
);
////////////////////////////////////////////////////////////////////////////////
// Helpers
// Saturating narrowing of a wide signed value to 32 bits
function signed [31:0] sat32;
    input signed [63:0] v;
    begin
        if (v > 64'sh000000007fffffff)
            sat32 = 32'sh7fffffff;
        else if (v < -64'sh0000000080000000)
            sat32 = 32'sh80000001;
        else
            sat32 = v[31:0];
    end
endfunction

// Gain multiply in Q16, then saturate
function signed [31:0] gmul;
    input signed [31:0] a;
    input signed [31:0] g;
    reg signed [63:0] p;
    begin
        p = (a * g) >>> 16;
        gmul = sat32(p);
    end
endfunction

function [31:0] absv;
    input signed [31:0] v;
    begin
        absv = v[31] ? (~v + 32'h00000001) : v;
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Configuration registers
reg [15:0]        profile_buf_reg;
reg [31:0]        jerk_reg;
reg [31:0]        accel_limit_reg;
reg [31:0]        decel_limit_reg;
reg [31:0]        qstop_decel_reg;
reg signed [31:0] vel_gain_reg [0:1];
reg signed [31:0] cur_gain_reg [0:1];
reg signed [31:0] flt_coef_reg [0:9];
reg [1:0]         flt_mode_reg [0:1];
reg [31:0]        peak_limit_reg;
reg [31:0]        cont_limit_reg;
reg [31:0]        peak_time_reg;
reg               cw_start_reg;
reg signed [31:0] vel_cmd_reg;
reg signed [31:0] cmd_current_reg;
reg signed [31:0] lim_current_reg;

wire prof_ok = (i_wdata[15:0] == `SVCL_PROF_TRAP)   ||
               (i_wdata[15:0] == `SVCL_PROF_SCURVE) ||
               (i_wdata[15:0] == `SVCL_PROF_VELOCITY); // RQ2
wire start_edge = i_control_word[`SVCL_CW_START_BIT] & ~cw_start_reg; // RQ20
wire [3:0] fsub = i_subindex[3:0] - 4'h1;
integer k;
integer j; // Loop state has its own index, k belongs to the write process

// Object writes; settings hold across reset release until written
always @(posedge i_clk) begin
    o_ack    <= 1'b0;
    o_reject <= 1'b0;
    if (i_reset) begin
        profile_buf_reg <= `SVCL_PROF_TRAP;
        jerk_reg        <= 32'h00000000;
        accel_limit_reg <= 32'hffffffff;
        decel_limit_reg <= 32'hffffffff;
        qstop_decel_reg <= 32'h00000000;
        peak_limit_reg  <= 32'h00000000;
        cont_limit_reg  <= 32'h00000000;
        peak_time_reg   <= 32'h00000000;
        for (k = 0; k < 2; k = k + 1) begin
            vel_gain_reg[k] <= 32'sh0;
            cur_gain_reg[k] <= 32'sh0;
            flt_mode_reg[k] <= `SVCL_FILT_BYPASS;
        end
        for (k = 0; k < 10; k = k + 1)
            flt_coef_reg[k] <= 32'sh0;
    end else if (i_wr) begin
        o_ack <= 1'b1;
        case (i_index)
            `SVCL_IDX_PROFILE_SELECT: begin
                if (prof_ok)
                    profile_buf_reg <= i_wdata[15:0];
                else
                    o_reject <= 1'b1; // RQ3
            end
            `SVCL_IDX_JERK: begin
                if (i_subindex == 8'h01)
                    jerk_reg <= i_wdata;
                else
                    o_reject <= 1'b1; // RQ6
            end
            `SVCL_IDX_ACCEL_LIMIT: accel_limit_reg <= i_wdata;
            `SVCL_IDX_DECEL_LIMIT: decel_limit_reg <= i_wdata;
            `SVCL_IDX_QSTOP_DECEL: qstop_decel_reg <= i_wdata;
            `SVCL_IDX_VEL_GAINS: begin
                if (i_subindex == 8'h01 || i_subindex == 8'h02)
                    vel_gain_reg[i_subindex[1]] <= i_wdata;
                else
                    o_reject <= 1'b1;
            end
            `SVCL_IDX_CUR_GAINS: begin
                if (i_subindex == 8'h01 || i_subindex == 8'h02)
                    cur_gain_reg[i_subindex[1]] <= i_wdata;
                else
                    o_reject <= 1'b1;
            end
            `SVCL_IDX_VEL_CMD_FILTER, `SVCL_IDX_VEL_OUT_FILTER: begin
                // Sub 0 mode; subs 1..5 b0 b1 b2 a1 a2
                if (i_subindex == 8'h00)
                    flt_mode_reg[i_index == `SVCL_IDX_VEL_OUT_FILTER] <= i_wdata[1:0];
                else if (i_subindex <= 8'h05)
                    flt_coef_reg[(i_index == `SVCL_IDX_VEL_OUT_FILTER ? 5 : 0)
                                 + fsub] <= i_wdata;
                else
                    o_reject <= 1'b1;
            end
            `SVCL_IDX_PEAK_LIMIT: begin
                // Peak limit never above the drive rating
                peak_limit_reg <= (i_wdata > PEAK_RATING) ? PEAK_RATING : i_wdata; // RQ14
            end
            `SVCL_IDX_CONT_LIMIT: cont_limit_reg <= i_wdata;
            `SVCL_IDX_PEAK_TIME:  peak_time_reg  <= i_wdata;
            default: o_reject <= 1'b1;
        endcase
    end else if (i_rd) begin
        o_ack <= 1'b1;
    end
end

// Object reads
always @(posedge i_clk) begin
    if (i_reset)
        o_rdata <= 32'h00000000;
    else if (i_rd) begin
        case (i_index)
            `SVCL_IDX_PROFILE_SELECT: o_rdata <= {{16{profile_buf_reg[15]}}, profile_buf_reg};
            `SVCL_IDX_JERK: o_rdata <= (i_subindex == 8'h00) ?
                                       {24'h000000, `SVCL_JERK_COUNT} : jerk_reg; // RQ6
            `SVCL_IDX_ACCEL_LIMIT:    o_rdata <= accel_limit_reg;
            `SVCL_IDX_DECEL_LIMIT:    o_rdata <= decel_limit_reg;
            `SVCL_IDX_QSTOP_DECEL:    o_rdata <= qstop_decel_reg;
            `SVCL_IDX_PEAK_LIMIT:     o_rdata <= peak_limit_reg;
            `SVCL_IDX_CONT_LIMIT:     o_rdata <= cont_limit_reg;
            `SVCL_IDX_PEAK_TIME:      o_rdata <= peak_time_reg;
            `SVCL_IDX_VEL_CMD_RO:     o_rdata <= vel_cmd_reg;
            `SVCL_IDX_CMD_CURRENT:    o_rdata <= cmd_current_reg;
            `SVCL_IDX_LIM_CURRENT:    o_rdata <= lim_current_reg;
            default:                  o_rdata <= 32'h00000000;
        endcase
    end
end
////////////////////////////////////////////////////////////////////////////////
// Profile latch on move start
always @(posedge i_clk) begin
    if (i_reset) begin
        cw_start_reg     <= 1'b0;
        o_active_profile <= `SVCL_PROF_TRAP;
    end else begin
        cw_start_reg <= i_control_word[`SVCL_CW_START_BIT];
        // Buffered value only moves on the start edge in position mode
        if (start_edge && i_profile_position_mode)
            o_active_profile <= profile_buf_reg; // RQ4 RQ5 RQ20
    end
end
////////////////////////////////////////////////////////////////////////////////
// Sample tick divider
reg [31:0] div_reg;
always @(posedge i_clk) begin
    if (i_reset) begin
        div_reg       <= 32'h00000000;
        o_sample_tick <= 1'b0;
    end else begin
        o_sample_tick <= (div_reg == SAMPLE_CYCLES - 1); // RQ21
        div_reg <= (div_reg == SAMPLE_CYCLES - 1) ? 32'h00000000 : div_reg + 32'h00000001;
    end
end
////////////////////////////////////////////////////////////////////////////////
// Biquad filter; mode picks which coefficients apply
reg signed [31:0] fx1 [0:1];
reg signed [31:0] fx2 [0:1];
reg signed [31:0] fy1 [0:1];
reg signed [31:0] fy2 [0:1];

function signed [31:0] filt;
    input [1:0]         mode;
    input [3:0]         base;
    input signed [31:0] x, x1, x2, y1, y2;
    reg signed [63:0]   acc;
    begin
        acc = 64'sh0;
        case (mode)
            `SVCL_FILT_BYPASS: acc = x <<< 16;
            `SVCL_FILT_SINGLE_POLE:
                acc = x * flt_coef_reg[base] - y1 * flt_coef_reg[base + 3];
            default: // Butterworth and custom biquad share the section
                acc = x * flt_coef_reg[base] + x1 * flt_coef_reg[base + 1]
                    + x2 * flt_coef_reg[base + 2] - y1 * flt_coef_reg[base + 3]
                    - y2 * flt_coef_reg[base + 4];
        endcase
        filt = sat32(acc >>> 16); // RQ12
    end
endfunction
////////////////////////////////////////////////////////////////////////////////
// Velocity loop
reg signed [31:0] vel_int_reg;
reg signed [31:0] cmd_filt_reg;
wire signed [31:0] cmd_in  = i_target_velocity;
wire signed [31:0] cmd_f   = filt(flt_mode_reg[0], 4'd0, cmd_in, fx1[0], fx2[0], fy1[0], fy2[0]);
wire signed [32:0] dv      = cmd_f - vel_cmd_reg;
wire        growing        = absv(cmd_f) > absv(vel_cmd_reg);
wire [31:0] qs_mag         = absv(vel_cmd_reg);
reg signed [31:0] vel_next;

// Ramp limiting and quick stop
always @* begin
    vel_next = vel_cmd_reg;
    if (i_quick_stop) begin
        if (qstop_decel_reg == 32'h00000000)
            vel_next = 32'sh0; // RQ1
        else if (qs_mag <= qstop_decel_reg)
            vel_next = 32'sh0; // RQ19
        else
            vel_next = vel_cmd_reg[31] ? vel_cmd_reg + qstop_decel_reg
                                       : vel_cmd_reg - qstop_decel_reg; // RQ19
    end else if (growing) begin
        if (dv > $signed({1'b0, accel_limit_reg}))
            vel_next = vel_cmd_reg + accel_limit_reg; // RQ7
        else if (dv < -$signed({1'b0, accel_limit_reg}))
            vel_next = vel_cmd_reg - accel_limit_reg; // RQ7
        else
            vel_next = cmd_f;
    end else begin
        if (dv > $signed({1'b0, decel_limit_reg}))
            vel_next = vel_cmd_reg + decel_limit_reg; // RQ8
        else if (dv < -$signed({1'b0, decel_limit_reg}))
            vel_next = vel_cmd_reg - decel_limit_reg; // RQ8
        else
            vel_next = cmd_f;
    end
end

wire signed [31:0] vel_err  = sat32(vel_next - i_actual_velocity); // RQ9
wire signed [31:0] vint_nx  = sat32(vel_int_reg + vel_err); // RQ10
wire signed [31:0] vel_raw  = sat32(gmul(vel_err, vel_gain_reg[0])
                                  + gmul(vint_nx, vel_gain_reg[1])); // RQ9 RQ10
wire signed [31:0] vel_out  = filt(flt_mode_reg[1], 4'd5, vel_raw,
                                   fx1[1], fx2[1], fy1[1], fy2[1]); // RQ11
////////////////////////////////////////////////////////////////////////////////
// Current limiter and current loop
reg [31:0] peak_cnt_reg;
reg signed [31:0] cur_int_reg;
wire [31:0] lim_mag = (peak_cnt_reg >= peak_time_reg) ? cont_limit_reg : peak_limit_reg; // RQ15
wire signed [31:0] lim_cur = (absv(vel_out) > lim_mag) ?
                             (vel_out[31] ? -$signed(lim_mag) : $signed(lim_mag))
                             : vel_out; // RQ13 RQ14
wire at_peak = absv(vel_out) > cont_limit_reg;
wire signed [31:0] cur_err = sat32(lim_cur - i_feedback_current); // RQ16
wire signed [31:0] cint_nx = sat32(cur_int_reg + cur_err); // RQ17
wire signed [31:0] cur_out = sat32(gmul(cur_err, cur_gain_reg[0])
                                 + gmul(cint_nx, cur_gain_reg[1])); // RQ16 RQ17

// Signed current output mapped onto duty around half scale
wire signed [31:0] duty_w = (cur_out >>> (32 - PWM_BITS)) + (32'sh1 <<< (PWM_BITS - 1));

// Sample update of all loop state in a single step
always @(posedge i_clk) begin
    if (i_reset) begin
        vel_cmd_reg     <= 32'sh0;
        vel_int_reg     <= 32'sh0;
        cur_int_reg     <= 32'sh0;
        cmd_current_reg <= 32'sh0;
        lim_current_reg <= 32'sh0;
        peak_cnt_reg    <= 32'h00000000;
        o_pwm_duty      <= {1'b1, {(PWM_BITS-1){1'b0}}};
        for (j = 0; j < 2; j = j + 1) begin
            fx1[j] <= 32'sh0;
            fx2[j] <= 32'sh0;
            fy1[j] <= 32'sh0;
            fy2[j] <= 32'sh0;
        end
    end else if (o_sample_tick) begin // RQ21
        vel_cmd_reg     <= vel_next;
        vel_int_reg     <= vint_nx;
        fx1[0]          <= cmd_in;
        fx2[0]          <= fx1[0];
        fy1[0]          <= cmd_f;
        fy2[0]          <= fy1[0];
        fx1[1]          <= vel_raw;
        fx2[1]          <= fx1[1];
        fy1[1]          <= vel_out;
        fy2[1]          <= fy1[1];
        cmd_current_reg <= vel_out; // RQ13
        lim_current_reg <= lim_cur;
        // Peak time counter resets once demand drops under continuous
        peak_cnt_reg    <= at_peak ? ((peak_cnt_reg == 32'hffffffff) ? peak_cnt_reg
                                      : peak_cnt_reg + 32'h00000001) : 32'h00000000; // RQ15
        cur_int_reg     <= cint_nx;
        o_pwm_duty      <= duty_w[PWM_BITS-1:0]; // RQ18
    end
end
////////////////////////////////////////////////////////////////////////////////
// PWM carrier
reg [PWM_BITS-1:0] pwm_cnt_reg;
always @(posedge i_clk) begin
    if (i_reset) begin
        pwm_cnt_reg <= {PWM_BITS{1'b0}};
        o_pwm_out   <= 1'b0;
    end else begin
        pwm_cnt_reg <= pwm_cnt_reg + {{(PWM_BITS-1){1'b0}}, 1'b1};
        o_pwm_out   <= pwm_cnt_reg < o_pwm_duty; // RQ18
    end
end

endmodule // svcl_servo_loops

// *** verif/svcl_servo_loops_checker.sv ***
`timescale 1ns/1ps
module svcl_servo_loops_checker #(
    parameter SAMPLE_CYCLES = 4,
    parameter PEAK_RATING   = 32'h00007fff,
    parameter PWM_BITS      = 12
) (
    input wire logic                i_clk,
    input wire logic                i_reset,
    input wire logic                i_wr,
    input wire logic                i_rd,
    input wire logic [15:0]         i_index,
    input wire logic [7:0]          i_subindex,
    input wire logic [31:0]         i_wdata,
    input wire logic [31:0]         o_rdata,
    input wire logic                o_ack,
    input wire logic                o_reject,
    input wire logic [15:0]         i_control_word,
    input wire logic                i_profile_position_mode,
    input wire logic [15:0]         o_active_profile,
    input wire logic                o_sample_tick,
    input wire logic [PWM_BITS-1:0] o_pwm_duty
);
    logic        prof_wr;
    logic        code_ok;
    logic        rd_only;
    logic [31:0] gap_reg;
    logic        seen_reg;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded accesses
    assign prof_wr = i_wr && i_index == 16'h6086;
    assign rd_only = i_rd && !i_wr;
    assign code_ok = i_wdata[15:0] == 16'h0000 || i_wdata[15:0] == 16'h0003
                     || i_wdata[15:0] == 16'hffff;

    // Cycles since last tick; first tick after reset only arms the check
    always @(posedge i_clk) begin
        if (i_reset) begin
            gap_reg  <= 32'h0;
            seen_reg <= 1'b0;
        end else begin
            gap_reg  <= o_sample_tick ? 32'h0 : gap_reg + 32'h1;
            seen_reg <= seen_reg | o_sample_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    property p_ack_pulse; (i_wr || i_rd) |=> o_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("no ack after access");
    property p_no_stray; (!i_wr && !i_rd) |=> !o_ack && !o_reject; endproperty
    a_no_stray: assert property (p_no_stray) else $error("ack without access");
    property p_bad_code; (prof_wr && !code_ok) |=> o_ack && o_reject; endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code accepted");
    property p_good_code; (prof_wr && code_ok) |=> o_ack && !o_reject; endproperty
    a_good_code: assert property (p_good_code) else $error("good code refused");
    property p_legal;
        o_active_profile == 16'h0000 || o_active_profile == 16'h0003
            || o_active_profile == 16'hffff;
    endproperty
    a_legal: assert property (p_legal) else $error("illegal active profile");
    // Profile only moves on a start edge seen in position mode
    property p_buffered;
        !(i_control_word[4] && !$past(i_control_word[4]) && i_profile_position_mode)
            |=> $stable(o_active_profile);
    endproperty
    a_buffered: assert property (p_buffered) else $error("profile moved early");
    property p_jerk; (rd_only && i_index == 16'h60a4 && i_subindex == 8'h00) |=> o_rdata == 32'h1;
    endproperty
    a_jerk: assert property (p_jerk) else $error("jerk count wrong");
    property p_peak; (rd_only && i_index == 16'h2110) |=> o_rdata <= PEAK_RATING; endproperty
    a_peak: assert property (p_peak) else $error("peak above rating");
    property p_period; seen_reg |-> (o_sample_tick == (gap_reg == SAMPLE_CYCLES - 1)); endproperty
    a_period: assert property (p_period) else $error("sample period wrong");
    // Duty may only move just after a loop update
    property p_duty;
        $changed(o_pwm_duty) |-> $past(o_sample_tick) || $past(o_sample_tick, 2);
    endproperty
    a_duty: assert property (p_duty) else $error("duty moved off tick");

    c_reject: cover property (o_reject);
    c_latch: cover property (i_control_word[4] && !$past(i_control_word[4]) && i_profile_position_mode);
    c_tick: cover property (o_sample_tick ##4 o_sample_tick);
endmodule // svcl_servo_loops_checker

bind svcl_servo_loops svcl_servo_loops_checker #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES), .PEAK_RATING(PEAK_RATING), .PWM_BITS(PWM_BITS)
) u_checker (
    .i_clk(i_clk), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd), .i_index(i_index),
    .i_subindex(i_subindex), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_ack(o_ack),
    .o_reject(o_reject), .i_control_word(i_control_word),
    .i_profile_position_mode(i_profile_position_mode), .o_active_profile(o_active_profile),
    .o_sample_tick(o_sample_tick), .o_pwm_duty(o_pwm_duty)
);

// *** verif/svcl_power_stage.sv ***
`timescale 1ns/1ps
module svcl_power_stage (
    input  wire logic          i_clk,
    input  wire logic          i_reset,
    input  wire logic          i_pwm_out,
    output logic signed [31:0] o_actual_velocity,
    output logic signed [31:0] o_feedback_current
);
    // Winding current climbs while the bridge is on, falls while off, with
    // an eighth leaking away per cycle; speed integrates current slowly
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_feedback_current <= 32'sh0;
            o_actual_velocity  <= 32'sh0;
        end else begin
            o_feedback_current <= o_feedback_current + (i_pwm_out ? 32'sd64 : -32'sd64)
                                  - (o_feedback_current >>> 3);
            o_actual_velocity  <= o_actual_velocity + (o_feedback_current >>> 6);
        end
    end
endmodule // svcl_power_stage

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic               i_clk = 1'b0;
    logic               i_reset, i_wr, i_rd, i_profile_position_mode, i_quick_stop;
    logic [15:0]        i_index, i_control_word;
    logic [7:0]         i_subindex;
    logic [31:0]        i_wdata, rd_val, v1;
    logic signed [31:0] i_target_velocity, d;
    wire  [31:0]        o_rdata;
    wire                o_ack, o_reject, o_sample_tick, o_pwm_out;
    wire  [15:0]        o_active_profile;
    wire  [11:0]        o_pwm_duty;
    wire signed [31:0]  act_vel, fb_cur;
    logic               rej;
    logic [15:0]        codes [3] = '{16'h0000, 16'h0003, 16'hffff};
    int                 n_errors = 0;
    int                 checked = 0;

    always #5 i_clk = ~i_clk;

    svcl_servo_loops #(.SAMPLE_CYCLES(4)) DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_wr(i_wr), .i_rd(i_rd), .i_index(i_index),
        .i_subindex(i_subindex), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_ack(o_ack),
        .o_reject(o_reject), .i_control_word(i_control_word),
        .i_profile_position_mode(i_profile_position_mode), .i_quick_stop(i_quick_stop),
        .i_target_velocity(i_target_velocity), .i_actual_velocity(act_vel),
        .i_feedback_current(fb_cur), .o_active_profile(o_active_profile),
        .o_sample_tick(o_sample_tick), .o_pwm_duty(o_pwm_duty), .o_pwm_out(o_pwm_out)
    );

    svcl_power_stage u_stage (
        .i_clk(i_clk), .i_reset(i_reset), .i_pwm_out(o_pwm_out),
        .o_actual_velocity(act_vel), .o_feedback_current(fb_cur)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task finish_test;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s seen %h want %h", $time, what, seen, exp);
        end
    endtask

    // One-cycle strobe, then wait a bounded time for the ack
    task acc(input logic rd, input logic [15:0] idx, input logic [7:0] sub,
             input logic [31:0] data);
        int k;
        @(negedge i_clk);
        i_rd = rd;
        i_wr = !rd;
        i_index = idx;
        i_subindex = sub;
        i_wdata = data;
        @(negedge i_clk);
        i_rd = 1'b0;
        i_wr = 1'b0;
        for (k = 0; k < 4 && o_ack !== 1'b1; k++) @(negedge i_clk);
        check({31'h0, o_ack}, 32'h1, "ack");
        rd_val = o_rdata;
        rej = o_reject;
    endtask

    task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data,
            input logic exp_rej);
        acc(1'b0, idx, sub, data);
        check({31'h0, rej}, {31'h0, exp_rej}, "reject flag");
    endtask

    task rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
        acc(1'b1, idx, sub, 32'h0);
        check(rd_val, exp, "read data");
    endtask

    task wait_tick;
        int k;
        for (k = 0; k < 12; k++) begin
            @(negedge i_clk);
            if (o_sample_tick === 1'b1) break;
        end
        check({31'h0, o_sample_tick}, 32'h1, "tick");
    endtask

    // Change of the velocity command across one loop update
    task step(output logic signed [31:0] delta);
        wait_tick();
        acc(1'b1, 16'h2250, 8'h00, 32'h0);
        v1 = rd_val;
        wait_tick();
        acc(1'b1, 16'h2250, 8'h00, 32'h0);
        delta = rd_val - v1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {i_reset, i_wr, i_rd, i_index, i_subindex, i_wdata} = {3'b100, 56'h0};
        {i_control_word, i_profile_position_mode, i_quick_stop} = 18'h0;
        i_target_velocity = 32'sh0;
        repeat (8) @(negedge i_clk);
        i_reset = 1'b0;
        check({20'h0, o_pwm_duty}, 32'h800, "duty reset");
        rd(16'h60c5, 8'h00, 32'hffffffff);
        rd(16'h60c6, 8'h00, 32'hffffffff);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            wr(16'h6086, 8'h00, {16'h0, codes[i]}, 1'b0);
            rd(16'h6086, 8'h00, {{16{codes[i][15]}}, codes[i]});
        end
        wr(16'h6086, 8'h00, 32'h5, 1'b1);
        wr(16'h6086, 8'h00, 32'h1, 1'b1);
        rd(16'h6086, 8'h00, 32'hffffffff);
        wr(16'h1234, 8'h00, 32'h1, 1'b1);
        rd(16'h60a4, 8'h00, 32'h1);
        wr(16'h60a4, 8'h01, 32'h55, 1'b0);
        rd(16'h60a4, 8'h01, 32'h55);
        $display("test profile codes done");
        wr(16'h6086, 8'h00, 32'h3, 1'b0);
        check({16'h0, o_active_profile}, 32'h0, "held");
        i_control_word = 16'h0010;
        repeat (2) @(negedge i_clk);
        check({16'h0, o_active_profile}, 32'h0, "outside mode");
        i_control_word = 16'h0000;
        i_profile_position_mode = 1'b1;
        @(negedge i_clk);
        i_control_word = 16'h0010;
        repeat (2) @(negedge i_clk);
        check({16'h0, o_active_profile}, 32'h3, "latched");
        wr(16'h6086, 8'h00, 32'h0, 1'b0);
        check({16'h0, o_active_profile}, 32'h3, "buffered");
        i_control_word = 16'h0000;
        $display("test buffering done");
        wr(16'h60c5, 8'h00, 32'd10, 1'b0);
        wr(16'h60c6, 8'h00, 32'd4, 1'b0);
        i_target_velocity = 32'sd100;
        step(d);
        check(d, 32'd10, "accel step");
        i_target_velocity = 32'sd0;
        step(d);
        check(d, -32'sd4, "decel step");
        $display("test ramp done");
        i_target_velocity = 32'sd100;
        wr(16'h6085, 8'h00, 32'd3, 1'b0);
        repeat (4) wait_tick();
        i_quick_stop = 1'b1;
        step(d);
        check(d, -32'sd3, "stop step");
        wr(16'h6085, 8'h00, 32'd0, 1'b0);
        wait_tick();
        rd(16'h2250, 8'h00, 32'h0);
        i_quick_stop = 1'b0;
        i_target_velocity = 32'sd0;
        $display("test quick stop done");
        wr(16'h2110, 8'h00, 32'hffffffff, 1'b0);
        rd(16'h2110, 8'h00, 32'h00007fff);
        wr(16'h2111, 8'h00, 32'h100, 1'b0);
        wr(16'h2112, 8'h00, 32'd20, 1'b0);
        wr(16'h60c5, 8'h00, 32'h7fffffff, 1'b0);
        wr(16'h2108, 8'h01, 32'h8000, 1'b0);
        wr(16'h2108, 8'h00, 32'h1, 1'b0);
        i_target_velocity = 32'sh01000000;
        wr(16'h2381, 8'h01, 32'h10000, 1'b0);
        repeat (3) wait_tick();
        v1 = act_vel;
        rd(16'h221d, 8'h00, 32'h00800000 - v1);
        rd(16'h2250, 8'h00, 32'h00800000);
        rd(16'h221e, 8'h00, 32'h7fff);
        repeat (20) wait_tick();
        rd(16'h221e, 8'h00, 32'h100);
        $display("test limits done");
        finish_test();
    end

    // Whole run needs well under this span
    initial begin
        #100000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        finish_test();
    end
endmodule // tb_top
